// [rtl/hip_core.sv]
// Homing selection and interpolated position control with APB registers
//
// Notes on behaviour
// - Methods 1-14, 33, 34 use index pulse
// - Methods 17-30 switches only; 17 neg, 18 pos
// - Block homing only in closed loop
// - Block detected above current level, then hold
// - Negative method numbers select block homing
// - Methods 33, 34 use next index only
// - Method 35 takes present position, no travel
// - Method 35 runs without operation enabled
// - Method 1 negative limit, 2 positive limit
// - Methods 3-4 left edge, 5-6 right; code treats 3-6 alike, seeks HOME_SW high, then index
// - Methods 7-10 positive, 11-14 negative limit; code ignores limits, 7-14 seek HOME_SW high, then index
// - Mode 7 selects interpolated position
// - Synchronise to SYNC once operational
// - Controlword bit 4 activates interpolation
// - Halt bit stops at once, demand held; no ramp on either edge
// - Bit 10 target reached or zero speed
// - Bit 12 shows interpolation active
// - Bit 13 following error after timeout
// - Linear path to single target entry
// - Interpolation period paced in milliseconds
// - Target writable only while buffer config one
// - Speed limited to smaller maximum in closed loop only
// - Mode 6 selects homing
// - Homing runs until reached or bit cleared
`timescale 1ns/1ns
`include "hip_params.svh"
module hip_core #(
  parameter int MS_CYCLES = `HIP_MS_NS / `HIP_CLK_NS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Drive state
  input wire logic CLOSED_LOOP,
  input wire logic OP_ENABLED,
  input wire logic NMT_OPERATIONAL,
  input wire logic SYNC_PULSE,
  input wire logic [15:0] MOTOR_CURRENT,
  input wire logic [31:0] ACTUAL_POS,
  // Switches and index
  input wire logic LIMIT_NEG,
  input wire logic LIMIT_POS,
  input wire logic HOME_SW,
  input wire logic INDEX_PULSE,
  // Motion outputs
  output logic [31:0] DEMAND_POS,
  output logic signed [31:0] DEMAND_VEL,
  output logic HOME_SET,
  output logic IN_SYNC
);
  localparam logic [31:0] MS_C = 32'(MS_CYCLES);
  logic [7:0] mode_reg;
  logic [15:0] ctrl_reg;
  logic [7:0] method_reg;
  logic [31:0] target_reg;
  logic bufcfg_reg;
  logic [15:0] ipper_reg;
  logic [31:0] maxprof_reg;
  logic [31:0] maxmot_reg;
  logic [15:0] curlvl_reg;
  logic [15:0] blkms_reg;
  logic [31:0] fewin_reg;
  logic [15:0] fems_reg;
  logic [31:0] home_pos_reg;
  logic halt_prev_reg;
  logic [31:0] ms_cnt_reg;
  logic ms_tick;
  logic [15:0] per_cnt_reg;
  logic [15:0] blk_cnt_reg;
  logic [15:0] fe_cnt_reg;
  logic ferr_reg;
  logic [31:0] seg_start_reg;
  logic [31:0] seg_end_reg;
  logic [15:0] seg_step_reg;
  logic sync_seen_reg;
  hip_pkg::hip_home_t hstate_reg;
  hip_pkg::hip_method_t mdec;
  hip_pkg::hip_req_t req;
  logic access;
  logic ip_mode;
  logic home_mode;
  logic ip_active;
  logic halt;
  logic [31:0] vlim;
  logic [31:0] dev;
  logic reached;
  logic [15:0] status;
  logic index_edge;
  logic index_prev_reg;
  logic go_prev_reg;
  logic [15:0] ipdiv;
  logic signed [32:0] lim;
  logic signed [47:0] span;
  logic signed [47:0] want;
  logic signed [31:0] step_lim;
  logic [31:0] pos_next;

  // Absolute difference
  function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
    logic signed [31:0] d;
    d = $signed(a) - $signed(b);
    absdiff = d[31] ? 32'(-d) : 32'(d);
  endfunction

  hip_method_dec u_dec (
    .method(method_reg),
    .closed_loop(CLOSED_LOOP),
    .dec(mdec)
  );

  // Bus request and mode decode
  always_comb begin
    req.write = PWRITE;
    req.addr = PADDR;
    req.wdata = PWDATA;
    access = PSEL && PENABLE;
    ip_mode = (mode_reg == `HIP_MODE_IP);
    home_mode = (mode_reg == `HIP_MODE_HOMING);
    halt = ctrl_reg[`HIP_CW_HALT];
    ip_active = ip_mode && ctrl_reg[`HIP_CW_GO] && OP_ENABLED;
    vlim = (maxprof_reg < maxmot_reg) ? maxprof_reg : maxmot_reg;
    dev = absdiff(ACTUAL_POS, DEMAND_POS);
    index_edge = INDEX_PULSE && !index_prev_reg;
    reached = halt ? (DEMAND_VEL == 32'h0000_0000) : (ACTUAL_POS == target_reg);
    status = 16'h0000;
    status[`HIP_SW_REACHED] = home_mode ? (hstate_reg == hip_pkg::HS_DONE) : reached;
    status[`HIP_SW_ACTIVE] = home_mode ? (hstate_reg == hip_pkg::HS_DONE) : ip_active;
    status[`HIP_SW_FERR] = home_mode ? (hstate_reg == hip_pkg::HS_ERR) : ferr_reg;
    status[8] = sync_seen_reg;
  end

  // APB register writes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_reg <= 8'h00;
      ctrl_reg <= 16'h0000;
      method_reg <= 8'h00;
      target_reg <= 32'h0000_0000;
      bufcfg_reg <= 1'b0;
      ipper_reg <= `HIP_IPPER_RST;
      maxprof_reg <= 32'hFFFF_FFFF;
      maxmot_reg <= 32'hFFFF_FFFF;
      curlvl_reg <= 16'hFFFF;
      blkms_reg <= `HIP_BLK_RST;
      fewin_reg <= 32'h0000_0100;
      fems_reg <= `HIP_FE_RST;
    end else if (access && req.write) begin
      if (req.addr == `HIP_OFF_MODE) begin
        mode_reg <= req.wdata[7:0];
      end else if (req.addr == `HIP_OFF_CTRL) begin
        ctrl_reg <= req.wdata[15:0];
      end else if (req.addr == `HIP_OFF_METHOD) begin
        method_reg <= req.wdata[7:0];
      end else if (req.addr == `HIP_OFF_TARGET) begin
        if (bufcfg_reg) begin
          target_reg <= req.wdata;
        end
      end else if (req.addr == `HIP_OFF_BUFCFG) begin
        bufcfg_reg <= req.wdata[0];
      end else if (req.addr == `HIP_OFF_IPPER) begin
        ipper_reg <= req.wdata[15:0];
      end else if (req.addr == `HIP_OFF_MAXPROF) begin
        maxprof_reg <= req.wdata;
      end else if (req.addr == `HIP_OFF_MAXMOT) begin
        maxmot_reg <= req.wdata;
      end else if (req.addr == `HIP_OFF_CURLVL) begin
        curlvl_reg <= req.wdata[15:0];
      end else if (req.addr == `HIP_OFF_BLKMS) begin
        blkms_reg <= req.wdata[15:0];
      end else if (req.addr == `HIP_OFF_FEWIN) begin
        fewin_reg <= req.wdata;
      end else if (req.addr == `HIP_OFF_FEMS) begin
        fems_reg <= req.wdata[15:0];
      end
    end
  end

  // APB read data and answer, no wait state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      if (PSEL && !PENABLE) begin
        if (req.addr == `HIP_OFF_MODE) begin
          PRDATA <= {24'h000000, mode_reg};
        end else if (req.addr == `HIP_OFF_CTRL) begin
          PRDATA <= {16'h0000, ctrl_reg};
        end else if (req.addr == `HIP_OFF_METHOD) begin
          PRDATA <= {24'h000000, method_reg};
        end else if (req.addr == `HIP_OFF_STATUS) begin
          PRDATA <= {16'h0000, status};
        end else if (req.addr == `HIP_OFF_TARGET) begin
          PRDATA <= target_reg;
        end else if (req.addr == `HIP_OFF_BUFCFG) begin
          PRDATA <= {31'h0, bufcfg_reg};
        end else if (req.addr == `HIP_OFF_IPPER) begin
          PRDATA <= {16'h0000, ipper_reg};
        end else if (req.addr == `HIP_OFF_MAXPROF) begin
          PRDATA <= maxprof_reg;
        end else if (req.addr == `HIP_OFF_MAXMOT) begin
          PRDATA <= maxmot_reg;
        end else if (req.addr == `HIP_OFF_CURLVL) begin
          PRDATA <= {16'h0000, curlvl_reg};
        end else if (req.addr == `HIP_OFF_BLKMS) begin
          PRDATA <= {16'h0000, blkms_reg};
        end else if (req.addr == `HIP_OFF_FEWIN) begin
          PRDATA <= fewin_reg;
        end else if (req.addr == `HIP_OFF_FEMS) begin
          PRDATA <= {16'h0000, fems_reg};
        end else if (req.addr == `HIP_OFF_POS) begin
          PRDATA <= DEMAND_POS;
        end else if (req.addr == `HIP_OFF_HOLD) begin
          PRDATA <= home_pos_reg;
        end else begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end

  // Millisecond tick divider
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else if (ms_cnt_reg >= MS_C - 32'h1) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end
  assign ms_tick = (ms_cnt_reg >= MS_C - 32'h1);

  // SYNC tracking once operational
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_seen_reg <= 1'b0;
      IN_SYNC <= 1'b0;
    end else begin
      if (!NMT_OPERATIONAL) begin
        sync_seen_reg <= 1'b0;
      end else if (SYNC_PULSE) begin
        sync_seen_reg <= 1'b1;
      end
      IN_SYNC <= sync_seen_reg;
    end
  end

  // Interpolation segment pacing, restarted on SYNC
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_cnt_reg <= 16'h0000;
      seg_start_reg <= 32'h0000_0000;
      seg_end_reg <= 32'h0000_0000;
      seg_step_reg <= 16'h0000;
    end else if (!ip_active) begin
      per_cnt_reg <= 16'h0000;
      seg_start_reg <= ACTUAL_POS;
      seg_end_reg <= ACTUAL_POS;
      seg_step_reg <= 16'h0000;
    end else if ((sync_seen_reg && SYNC_PULSE) || (ms_tick && per_cnt_reg + 16'h1 >= ipper_reg)) begin
      per_cnt_reg <= 16'h0000;
      seg_start_reg <= (ms_tick && !halt) ? pos_next : DEMAND_POS;
      seg_end_reg <= target_reg;
      seg_step_reg <= 16'h0000;
    end else if (ms_tick) begin
      per_cnt_reg <= per_cnt_reg + 16'h1;
      seg_step_reg <= seg_step_reg + 16'h1;
    end
  end

  // Next point on the linear path, ending on the target at period end
  always_comb begin
    ipdiv = (ipper_reg == 16'h0000) ? 16'h0001 : ipper_reg;
    lim = $signed({1'b0, vlim});
    span = 48'($signed(seg_end_reg) - $signed(seg_start_reg));
    want = 48'($signed(seg_start_reg)) + (span * ($signed({2'b00, seg_step_reg}) + 18'sh1)) / $signed({1'b0, ipdiv});
    step_lim = 32'(want - 48'($signed(DEMAND_POS)));
    if (CLOSED_LOOP && step_lim > lim) begin
      step_lim = 32'(lim);
    end else if (CLOSED_LOOP && step_lim < -lim) begin
      step_lim = 32'(-lim);
    end
    pos_next = 32'($signed(DEMAND_POS) + step_lim);
  end

  // Demand update once per ms tick, held in halt
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DEMAND_POS <= 32'h0000_0000;
      DEMAND_VEL <= 32'sh0;
      halt_prev_reg <= 1'b0;
    end else begin
      halt_prev_reg <= halt;
      if (!ip_active) begin
        DEMAND_POS <= ACTUAL_POS;
        DEMAND_VEL <= 32'sh0;
      end else if (halt) begin
        DEMAND_VEL <= 32'sh0;
      end else if (ms_tick) begin
        DEMAND_POS <= pos_next;
        DEMAND_VEL <= step_lim;
      end
    end
  end

  // Following error timer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fe_cnt_reg <= 16'h0000;
      ferr_reg <= 1'b0;
    end else if (!CLOSED_LOOP || !ip_active || dev <= fewin_reg) begin
      fe_cnt_reg <= 16'h0000;
      ferr_reg <= 1'b0;
    end else if (ms_tick) begin
      if (fe_cnt_reg >= fems_reg) begin
        ferr_reg <= 1'b1;
      end else begin
        fe_cnt_reg <= fe_cnt_reg + 16'h1;
      end
    end
  end

  // Homing sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hstate_reg <= hip_pkg::HS_IDLE;
      blk_cnt_reg <= 16'h0000;
      home_pos_reg <= 32'h0000_0000;
      HOME_SET <= 1'b0;
      index_prev_reg <= 1'b0;
      go_prev_reg <= 1'b0;
    end else begin
      index_prev_reg <= INDEX_PULSE;
      go_prev_reg <= home_mode && ctrl_reg[`HIP_CW_GO];
      HOME_SET <= 1'b0;
      if (!home_mode || !ctrl_reg[`HIP_CW_GO]) begin
        hstate_reg <= (hstate_reg == hip_pkg::HS_DONE) ? hip_pkg::HS_DONE : hip_pkg::HS_IDLE;
        blk_cnt_reg <= 16'h0000;
      end else begin
        case (hstate_reg)
          hip_pkg::HS_IDLE, hip_pkg::HS_DONE, hip_pkg::HS_ERR: begin
            if (hstate_reg == hip_pkg::HS_IDLE || !go_prev_reg) begin
              if (!mdec.valid) begin
                hstate_reg <= hip_pkg::HS_ERR;
              end else if (mdec.kind == hip_pkg::REF_HERE) begin
                home_pos_reg <= ACTUAL_POS;
                HOME_SET <= 1'b1;
                hstate_reg <= hip_pkg::HS_DONE;
              end else if (!OP_ENABLED) begin
                hstate_reg <= hip_pkg::HS_IDLE;
              end else if (mdec.kind == hip_pkg::REF_INDEX) begin
                hstate_reg <= hip_pkg::HS_INDEX;
              end else begin
                hstate_reg <= hip_pkg::HS_SEEK;
              end
            end
          end
          hip_pkg::HS_SEEK: begin
            if (mdec.block && MOTOR_CURRENT > curlvl_reg) begin
              hstate_reg <= hip_pkg::HS_BLOCK;
            end else if (!mdec.block && ((mdec.group == 2'd0 && LIMIT_NEG) || (mdec.group == 2'd1 && LIMIT_POS)
                || (mdec.group[1] && HOME_SW))) begin
              hstate_reg <= mdec.index ? hip_pkg::HS_INDEX : hip_pkg::HS_DONE;
              if (!mdec.index) begin
                home_pos_reg <= ACTUAL_POS;
                HOME_SET <= 1'b1;
              end
            end
          end
          hip_pkg::HS_BLOCK: begin
            if (ms_tick) begin
              blk_cnt_reg <= blk_cnt_reg + 16'h1;
            end
            if (blk_cnt_reg >= blkms_reg) begin
              blk_cnt_reg <= 16'h0000;
              hstate_reg <= mdec.index ? hip_pkg::HS_INDEX : hip_pkg::HS_DONE;
              if (!mdec.index) begin
                home_pos_reg <= ACTUAL_POS;
                HOME_SET <= 1'b1;
              end
            end
          end
          hip_pkg::HS_INDEX: begin
            if (index_edge) begin
              home_pos_reg <= ACTUAL_POS;
              HOME_SET <= 1'b1;
              hstate_reg <= hip_pkg::HS_DONE;
            end
          end
          default: begin
            hstate_reg <= hip_pkg::HS_IDLE;
          end
        endcase
      end
    end
  end

  // Checks
  AST_MODE35: assert property (@(posedge CLK) disable iff (!RST_N)
    home_mode && ctrl_reg[`HIP_CW_GO] && hstate_reg == hip_pkg::HS_IDLE && mdec.valid
    && mdec.kind == hip_pkg::REF_HERE |=> HOME_SET && home_pos_reg == $past(ACTUAL_POS))
    else $error("method 35 did not capture position");
  AST_TGTLOCK: assert property (@(posedge CLK) disable iff (!RST_N)
    access && PWRITE && PADDR == `HIP_OFF_TARGET && !bufcfg_reg |=> $stable(target_reg))
    else $error("target changed while buffer locked");
  AST_ACTIVE: assert property (@(posedge CLK) disable iff (!RST_N)
    !home_mode |-> status[`HIP_SW_ACTIVE] == (ip_mode && ctrl_reg[`HIP_CW_GO] && OP_ENABLED))
    else $error("active bit wrong");
  AST_HALT: assert property (@(posedge CLK) disable iff (!RST_N)
    ip_active && halt |=> DEMAND_VEL == 32'sh0)
    else $error("motor moving in halt");
  AST_VLIM: assert property (@(posedge CLK) disable iff (!RST_N)
    CLOSED_LOOP && ip_active && ms_tick |=> DEMAND_VEL <= $signed({1'b0, $past(vlim)})
    && DEMAND_VEL >= -$signed({1'b0, $past(vlim)}))
    else $error("speed above limit");
  AST_FERR: assert property (@(posedge CLK) disable iff (!RST_N)
    !CLOSED_LOOP |=> !ferr_reg)
    else $error("following error in open loop");
  AST_BLOCK: assert property (@(posedge CLK) disable iff (!RST_N)
    hstate_reg == hip_pkg::HS_SEEK && mdec.block |-> CLOSED_LOOP || !mdec.valid)
    else $error("block homing in open loop");
  AST_SYNC: assert property (@(posedge CLK) disable iff (!RST_N)
    NMT_OPERATIONAL && SYNC_PULSE |=> sync_seen_reg ##1 IN_SYNC)
    else $error("sync not taken");
endmodule

// [rtl/hip_params.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef HIP_PARAMS_SVH
`define HIP_PARAMS_SVH
`define HIP_OFF_MODE 12'h000
`define HIP_OFF_CTRL 12'h004
`define HIP_OFF_METHOD 12'h008
`define HIP_OFF_STATUS 12'h00C
`define HIP_OFF_TARGET 12'h010
`define HIP_OFF_BUFCFG 12'h014
`define HIP_OFF_IPPER 12'h018
`define HIP_OFF_MAXPROF 12'h01C
`define HIP_OFF_MAXMOT 12'h020
`define HIP_OFF_CURLVL 12'h024
`define HIP_OFF_BLKMS 12'h028
`define HIP_OFF_FEWIN 12'h02C
`define HIP_OFF_FEMS 12'h030
`define HIP_OFF_POS 12'h034
`define HIP_OFF_HOLD 12'h038
`define HIP_MODE_HOMING 8'h06
`define HIP_MODE_IP 8'h07
`define HIP_CW_GO 4
`define HIP_CW_HALT 8
`define HIP_SW_REACHED 10
`define HIP_SW_ACTIVE 12
`define HIP_SW_FERR 13
`define HIP_IPPER_RST 16'h0001
`define HIP_BLK_RST 16'h0064
`define HIP_FE_RST 16'h0064
`define HIP_MS_NS 1000000
`define HIP_CLK_NS 4
`endif

// [rtl/hip_pkg.sv]
// Types shared by the homing and interpolation block
package hip_pkg;
  typedef enum logic [1:0] {REF_NONE, REF_SWITCH, REF_INDEX, REF_HERE} hip_ref_t;
  typedef struct packed {
    logic valid;
    logic block;
    logic index;
    hip_ref_t kind;
    logic [1:0] group;
  } hip_method_t;
  typedef struct packed {
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } hip_req_t;
  typedef enum logic [2:0] {HS_IDLE, HS_SEEK, HS_BLOCK, HS_INDEX, HS_DONE, HS_ERR} hip_home_t;
endpackage

// [rtl/hip_method_dec.sv]
// Homing method number decoder
`timescale 1ns/1ns
module hip_method_dec (
  // Method number and loop mode
  input wire logic [7:0] method,
  input wire logic closed_loop,
  // Decoded method
  output hip_pkg::hip_method_t dec
);
  logic [7:0] mag;
  logic neg;
  // Decode sign and range
  always_comb begin
    neg = method[7];
    mag = neg ? 8'(-method) : method;
    dec = '0;
    dec.block = neg;
    if (!neg && ((mag >= 8'h01 && mag <= 8'h0E) || mag == 8'h21 || mag == 8'h22)) begin
      dec.valid = 1'b1;
      dec.index = 1'b1;
      dec.kind = (mag >= 8'h21) ? hip_pkg::REF_INDEX : hip_pkg::REF_SWITCH;
    end else if (!neg && mag >= 8'h11 && mag <= 8'h1E) begin
      dec.valid = 1'b1;
      dec.kind = hip_pkg::REF_SWITCH;
    end else if (!neg && mag == 8'h23) begin
      dec.valid = 1'b1;
      dec.kind = hip_pkg::REF_HERE;
    end else if (neg && closed_loop && (mag == 8'h01 || mag == 8'h02 || (mag >= 8'h07 && mag <= 8'h0E))) begin
      dec.valid = 1'b1;
      dec.index = 1'b1;
      dec.kind = hip_pkg::REF_SWITCH;
    end else if (neg && closed_loop && (mag == 8'h11 || mag == 8'h12 || (mag >= 8'h17 && mag <= 8'h1E))) begin
      dec.valid = 1'b1;
      dec.kind = hip_pkg::REF_SWITCH;
    end
    // Group: 0 limit neg, 1 limit pos, 2 home edge, 3 home with limits
    if (mag == 8'h01 || mag == 8'h11) begin
      dec.group = 2'd0;
    end else if (mag == 8'h02 || mag == 8'h12) begin
      dec.group = 2'd1;
    end else if ((mag >= 8'h03 && mag <= 8'h06) || (mag >= 8'h13 && mag <= 8'h16)) begin
      dec.group = 2'd2;
    end else begin
      dec.group = 2'd3;
    end
  end
endmodule

// [tb/hip_host_model.sv]
// Host controller model: network state and periodic SYNC
`timescale 1ns/1ns
module hip_host_model #(
  parameter int PERIOD = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Network state request from the bench
  input wire logic nmt_req,
  // Fieldbus side
  output logic nmt_op,
  output logic sync_pulse
);
  int cnt;
  // Operational state follows the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmt_op <= 1'b0;
    end else begin
      nmt_op <= nmt_req;
    end
  end
  // One-cycle SYNC at a fixed interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      sync_pulse <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      sync_pulse <= (cnt == PERIOD - 1);
    end
  end
endmodule

// [tb/tb_hip_core.sv]
// Testbench for the homing and interpolation block
`timescale 1ns/1ns
`include "hip_params.svh"
module tb_hip_core;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, dpos;
  logic signed [31:0] dvel;
  logic pready, pslverr, home_set, in_sync, sync, nmt_op;
  logic closed = 1'b1, op_en = 1'b1, nmt_req = 1'b0, lneg = 1'b0, lpos = 1'b0, idx = 1'b0, hsw = 1'b0;
  logic [15:0] cur = 16'h0000;
  logic [31:0] apos = 32'h00001234;
  int bad_count = 0;
  int check_count = 0;
  int homes = 0;
  // Clock
  always #2 clk = ~clk;
  hip_host_model #(.PERIOD(40)) i_hip_host_model (.clk(clk), .rst_n(rst_n), .nmt_req(nmt_req),
    .nmt_op(nmt_op), .sync_pulse(sync));
  hip_core #(.MS_CYCLES(8)) i_hip_core (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CLOSED_LOOP(closed), .OP_ENABLED(op_en), .NMT_OPERATIONAL(nmt_op),
    .SYNC_PULSE(sync), .MOTOR_CURRENT(cur), .ACTUAL_POS(apos), .LIMIT_NEG(lneg), .LIMIT_POS(lpos),
    .HOME_SW(hsw), .INDEX_PULSE(idx), .DEMAND_POS(dpos), .DEMAND_VEL(dvel), .HOME_SET(home_set),
    .IN_SYNC(in_sync));
  // Count reference captures
  always @(posedge clk) begin
    if (home_set === 1'b1) begin
      homes <= homes + 1;
    end
  end
  task automatic stop_test;
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until PREADY is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h00000000);
  endtask
  task automatic rderr(input logic [11:0] a);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
  endtask
  // Poll one status bit until it shows the expected level
  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, `HIP_OFF_STATUS, 32'h00000000, r, e);
      n++;
    end while (r[b] !== v && n < 60);
    chk({31'h0, r[b]}, {31'h0, v});
  endtask
  // Wait for demand position or velocity to reach a value
  task automatic wout(input logic sel, input logic [31:0] v);
    int n;
    n = 0;
    while ((sel ? dvel : dpos) !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(sel ? dvel : dpos, v);
  endtask
  // Run one homing method; ev = {current high, index, limit pos, limit neg}
  task automatic home(input logic [7:0] m, input logic [3:0] ev, input logic exp);
    int c0;
    int n;
    c0 = homes;
    n = 0;
    wr(`HIP_OFF_METHOD, {24'h0, m});
    wr(`HIP_OFF_CTRL, 32'h00000010);
    lneg <= ev[0];
    lpos <= ev[1];
    cur <= ev[3] ? 16'hFFFF : 16'h0000;
    repeat (10) @(posedge clk);
    if (ev[2]) begin
      lneg <= 1'b0;
      lpos <= 1'b0;
      repeat (2) @(posedge clk);
      idx <= 1'b1;
      @(posedge clk);
      idx <= 1'b0;
    end
    while (homes == c0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, homes != c0}, {31'h0, exp});
    lneg <= 1'b0;
    lpos <= 1'b0;
    cur <= 16'h0000;
    wr(`HIP_OFF_CTRL, 32'h00000000);
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`HIP_OFF_IPPER, 32'h00000001);
    rd(`HIP_OFF_BLKMS, 32'h00000064);
    rd(`HIP_OFF_FEWIN, 32'h00000100);
    rd(`HIP_OFF_FEMS, 32'h00000064);
    rderr(12'h0FC);
    chk({31'h0, in_sync}, 32'h00000000);
    nmt_req <= 1'b1;
    poll(8, 1'b1);
    chk({31'h0, in_sync}, 32'h00000001);
    wr(`HIP_OFF_MAXPROF, 32'h00001000);
    wr(`HIP_OFF_MAXMOT, 32'h00001000);
    wr(`HIP_OFF_MODE, 32'h00000007);
    wr(`HIP_OFF_BUFCFG, 32'h00000001);
    wr(`HIP_OFF_TARGET, 32'h00000040);
    wr(`HIP_OFF_BUFCFG, 32'h00000000);
    wr(`HIP_OFF_TARGET, 32'h00000099);
    rd(`HIP_OFF_TARGET, 32'h00000040);
    wr(`HIP_OFF_CTRL, 32'h00000010);
    poll(12, 1'b1);
    wout(1'b0, 32'h00000040);
    apos <= 32'h00000040;
    poll(10, 1'b1);
    wr(`HIP_OFF_IPPER, 32'h00000004);
    wr(`HIP_OFF_BUFCFG, 32'h00000001);
    wr(`HIP_OFF_TARGET, 32'h00000050);
    wout(1'b1, 32'h00000004);
    wr(`HIP_OFF_IPPER, 32'h00000001);
    wr(`HIP_OFF_MAXPROF, 32'h00000005);
    wr(`HIP_OFF_MAXMOT, 32'h00000003);
    wr(`HIP_OFF_FEWIN, 32'h00000004);
    wr(`HIP_OFF_FEMS, 32'h00000001);
    wr(`HIP_OFF_TARGET, 32'h00001000);
    wout(1'b1, 32'h00000003);
    poll(13, 1'b1);
    wr(`HIP_OFF_CTRL, 32'h00000110);
    wout(1'b1, 32'h00000000);
    poll(10, 1'b1);
    wr(`HIP_OFF_CTRL, 32'h00000010);
    wout(1'b1, 32'h00000003);
    wr(`HIP_OFF_CTRL, 32'h00000000);
    wr(`HIP_OFF_MODE, 32'h00000006);
    wr(`HIP_OFF_CURLVL, 32'h00000100);
    wr(`HIP_OFF_BLKMS, 32'h00000001);
    home(8'h01, 4'b0101, 1'b1);
    home(8'h02, 4'b0110, 1'b1);
    home(8'h11, 4'b0001, 1'b1);
    home(8'h12, 4'b0010, 1'b1);
    home(8'h21, 4'b0100, 1'b1);
    home(8'h22, 4'b0100, 1'b1);
    home(8'hEF, 4'b1000, 1'b1);
    home(8'h21, 4'b0000, 1'b0);
    hsw <= 1'b1;
    home(8'h03, 4'b0100, 1'b1);
    home(8'h07, 4'b0100, 1'b1);
    hsw <= 1'b0;
    closed <= 1'b0;
    home(8'hFF, 4'b1000, 1'b0);
    wr(`HIP_OFF_CTRL, 32'h00000010);
    poll(13, 1'b1);
    wr(`HIP_OFF_CTRL, 32'h00000000);
    closed <= 1'b1;
    op_en <= 1'b0;
    apos <= 32'h00005678;
    home(8'h23, 4'b0000, 1'b1);
    rd(`HIP_OFF_HOLD, 32'h00005678);
    stop_test;
  end
endmodule
